// File: hdl/vlc_map.svh
`ifndef VLC_MAP_SVH
`define VLC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VLC_OFS_LINE_CONFIG     8'h00
`define VLC_OFS_TRANSMIT_CONFIG 8'h01
`define VLC_OFS_DIAG_CONFIG     8'h02
`define VLC_OFS_MODE_COMMAND    8'h03
`define VLC_OFS_LINE_STATE      8'h04

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VLC_RST_LINE_CONFIG     8'h00
`define VLC_RST_MAX_RETRY       4'h0
`define VLC_RST_MODULE_KIND     1'b0
`define VLC_RST_DIAG_CONFIG     8'h00
`define VLC_READ_ABSENT         8'h00

// ----------------------------------------------------------------
// Line configuration fields
// ----------------------------------------------------------------
`define VLC_LC_BAUD_HI          7
`define VLC_LC_BAUD_LO          4
`define VLC_LC_PULSE            3
`define VLC_LC_TX_FLIP          1
`define VLC_LC_RX_FLIP          0

// ----------------------------------------------------------------
// Transmit configuration fields
// ----------------------------------------------------------------
`define VLC_TC_RETRY_HI         7
`define VLC_TC_RETRY_LO         4
`define VLC_TC_KIND             0

// ----------------------------------------------------------------
// Diagnosis configuration fields
// ----------------------------------------------------------------
`define VLC_DC_SDC_HI           7
`define VLC_DC_SDC_LO           4
`define VLC_DC_SEL_HI           3
`define VLC_DC_SEL_LO           2
`define VLC_DC_TX_DIAG          1
`define VLC_DC_SDC_EN           0

// ----------------------------------------------------------------
// Command bits
// ----------------------------------------------------------------
`define VLC_CMD_RESET           7
`define VLC_CMD_SLEEP           6
`define VLC_CMD_IDLE            5
`define VLC_CMD_ACTIVE          4
`define VLC_CMD_REARB           3
`define VLC_CMD_MANUAL_TICK     0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define VLC_TS_SLOTS_PER_BIT    8'h10
`define VLC_SDC_BASE_DIV        22'h00_0040
`define VLC_MANUAL_TICK_SLOTS   2'h2
`define VLC_SEL_AUTO            2'h3

`endif

// File: hdl/vlc_pkg.sv
package vlc_pkg;

	// Gray coded along idle <-> active and idle <-> sleep.
	typedef enum logic [1:0] {
		VLC_MODE_IDLE   = 2'h0,
		VLC_MODE_ACTIVE = 2'h1,
		VLC_MODE_SLEEP  = 2'h2
	} vlc_mode_t;

	typedef logic [3:0] vlc_code_t;

endpackage

// File: hdl/vlc_tick_if.sv
`timescale 1ns/1ps
interface vlc_tick_if;
	import vlc_pkg::*;
	logic      run;
	logic      clear;
	vlc_code_t baud_divider;
	vlc_code_t sdc_code;
	logic      sdc_enable;
	logic      ts_tick;
	logic      sdc_tick;

	modport gen  (input run, input clear, input baud_divider, input sdc_code, input sdc_enable,
	              output ts_tick, output sdc_tick);
	modport user (output run, output clear, output baud_divider, output sdc_code, output sdc_enable,
	              input ts_tick, input sdc_tick);
endinterface

// File: hdl/vlc_clock_gen.sv
`timescale 1ns/1ps
`include "vlc_map.svh"
module vlc_clock_gen
	import vlc_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Tick carrier
	vlc_tick_if.gen   tk
);

	logic [7:0]  ts_cnt;
	logic [7:0]  next_ts_cnt;
	logic [7:0]  ts_limit;
	logic        next_ts_tick;
	logic [21:0] sdc_cnt;
	logic [21:0] next_sdc_cnt;
	logic [21:0] sdc_limit;
	logic        next_sdc_tick;

	// ----------------------------------------------------------------
	// Dividers
	// ----------------------------------------------------------------
	always_comb begin
		// A zero divider would stall the bus, so it runs as divide by one.
		ts_limit = (tk.baud_divider == 4'h0) ? `VLC_TS_SLOTS_PER_BIT - 8'h01
		         : 8'({tk.baud_divider, 4'h0} - 8'h01);
		sdc_limit = 22'((`VLC_SDC_BASE_DIV << tk.sdc_code) - 22'h00_0001);
		next_ts_cnt   = ts_cnt;
		next_ts_tick  = 1'b0;
		next_sdc_cnt  = sdc_cnt;
		next_sdc_tick = 1'b0;
		if (tk.clear || !tk.run) begin
			next_ts_cnt = 8'h00;
		end else if (ts_cnt >= ts_limit) begin
			next_ts_cnt  = 8'h00;
			next_ts_tick = 1'b1;
		end else begin
			next_ts_cnt = ts_cnt + 8'h01;
		end
		if (tk.clear || !tk.sdc_enable) begin
			next_sdc_cnt = 22'h00_0000;
		end else if (tk.ts_tick) begin
			if (sdc_cnt >= sdc_limit) begin
				next_sdc_cnt  = 22'h00_0000;
				next_sdc_tick = 1'b1;
			end else begin
				next_sdc_cnt = sdc_cnt + 22'h00_0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ts_cnt      <= 8'h00;
			tk.ts_tick  <= 1'b0;
			sdc_cnt     <= 22'h00_0000;
			tk.sdc_tick <= 1'b0;
		end else begin
			ts_cnt      <= next_ts_cnt;
			tk.ts_tick  <= next_ts_tick;
			sdc_cnt     <= next_sdc_cnt;
			tk.sdc_tick <= next_sdc_tick;
		end
	end

endmodule // vlc_clock_gen

// File: hdl/vlc_line_regs.sv
`timescale 1ns/1ps
`include "vlc_map.svh"
// Overview of operation
// - Timeslot clock is crystal over n times sixteen.
// - Pulsed coding uses input zero, no diagnosis.
// - Polarity bits invert transmit output, receive inputs.
// - Retries limited to max_retry, transmissions plus one.
// - Lost contention never counts; retry without limit.
// - module_kind one allows autonomous module behaviour.
// - Diagnosis tick divides timeslot by 64 shifted.
// - Select bits force an input or choose automatically.
// - tx_diag_enable gates window; diagnosis config resets zero.
// - diag_tick_divider_enable switches the tick divider.
// - Commands act within six timeslots; status confirms.
// - Soft reset acts as reset pin, self clears.
// - Sleep stops oscillator; idle, active or soft reset wakes.
// - Idle keeps oscillator, no traffic, transmit floats.
// - Active mode enables bus traffic and transmit driver.
// - Re-arbitrate after attempt clears retries, reselects.
// - Line status shows two-bit diagnosis state, reset value.
// - Mismatch flag sets on disagreement, clears on return.
// - Pending and activity flags track transmitter and bus.
// - Return-to-idle pulse per end of frame, not automatic.
module vlc_line_regs
	import vlc_pkg::*;
#(
	parameter logic [2:0] REVISION = 3'h5 // Arbitrary neutral value.
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Host register port
	input  wire logic       cpu_sel,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata,
	// Line pins
	input  wire logic       line_rx_in0,
	input  wire logic       line_rx_in1,
	input  wire logic       line_rx_in2,
	output logic            line_tx_out,
	output logic            line_tx_oe,
	// Frame engine side
	input  wire logic       tx_bit,
	input  wire logic       tx_in_progress,
	input  wire logic       tx_selected,
	input  wire logic       bus_busy,
	input  wire logic       eof_detect,
	input  wire logic       tx_error_evt,
	input  wire logic       contention_evt,
	input  wire logic       tx_success_evt,
	input  wire logic [1:0] diag_result,
	output logic            rx_data,
	output logic            frame_enable,
	output logic            pulse_coding_sel,
	output logic            diag_enable,
	output logic            module_kind,
	output logic            retry_req,
	output logic            retry_exhausted,
	output logic      [3:0] retry_count,
	output logic            arbitration_restart,
	output logic            tx_active_window,
	output logic            sync_diag_tick,
	output logic            return_to_idle_pulse,
	output logic      [1:0] diag_select,
	output logic            osc_run,
	output logic            timeslot_clock
);

	vlc_tick_if tk();

	vlc_clock_gen u_clock_gen (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.tk      (tk)
	);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] line_config,     next_line_config;
	logic [3:0] max_retry,       next_max_retry;
	logic       next_module_kind;
	logic [7:0] diagnosis_config, next_diagnosis_config;
	vlc_mode_t  mode,            next_mode;
	logic [2:0] cmd_pend,        next_cmd_pend;
	logic       rearb_pend,      next_rearb_pend;
	logic [1:0] manual_cnt,      next_manual_cnt;
	logic       soft_rst,        next_soft_rst;
	logic       input_mismatch_flag, next_input_mismatch_flag;
	logic       tx_pending_flag, next_tx_pending_flag;
	logic       bus_activity_flag, next_bus_activity_flag;
	logic [1:0] diag_state,      next_diag_state;
	logic [3:0] next_retry_count;
	logic [7:0] next_cpu_rdata;
	logic       next_line_tx_out, next_line_tx_oe, next_rx_data;
	logic       next_retry_req, next_retry_exhausted, next_arbitration_restart;
	logic       next_tx_active_window, next_sync_diag_tick, next_return_to_idle_pulse;
	logic       wr_hit, rd_hit, mism_now, attempt_end, ri_now;
	logic [2:0] rx_in;
	logic [1:0] eff_sel;

	assign wr_hit = cpu_sel && cpu_wr;
	assign rd_hit = cpu_sel && cpu_rd;

	// The dividers stop with the oscillator and restart cleanly after a soft reset.
	assign tk.run          = (mode != VLC_MODE_SLEEP);
	assign tk.clear        = soft_rst;
	assign tk.baud_divider = line_config[`VLC_LC_BAUD_HI:`VLC_LC_BAUD_LO];
	assign tk.sdc_code     = diagnosis_config[`VLC_DC_SDC_HI:`VLC_DC_SDC_LO];
	assign tk.sdc_enable   = diagnosis_config[`VLC_DC_SDC_EN] && (mode != VLC_MODE_SLEEP);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_line_config      = line_config;
		next_max_retry        = max_retry;
		next_module_kind      = module_kind;
		next_diagnosis_config = diagnosis_config;
		next_mode             = mode;
		next_cmd_pend         = cmd_pend;
		next_rearb_pend       = rearb_pend;
		next_manual_cnt       = manual_cnt;
		next_soft_rst         = 1'b0;
		next_retry_count      = retry_count;
		next_retry_req        = 1'b0;
		next_retry_exhausted  = 1'b0;
		next_arbitration_restart = 1'b0;
		next_cpu_rdata        = cpu_rdata;

		// Host writes. The revision field is fixed and never stored.
		if (wr_hit) begin
			case (cpu_addr)
				`VLC_OFS_LINE_CONFIG: begin
					next_line_config = cpu_wdata;
				end
				`VLC_OFS_TRANSMIT_CONFIG: begin
					next_max_retry   = cpu_wdata[`VLC_TC_RETRY_HI:`VLC_TC_RETRY_LO];
					next_module_kind = cpu_wdata[`VLC_TC_KIND];
				end
				`VLC_OFS_DIAG_CONFIG: begin
					next_diagnosis_config = cpu_wdata;
				end
				`VLC_OFS_MODE_COMMAND: begin
					next_soft_rst = cpu_wdata[`VLC_CMD_RESET];
					next_cmd_pend = next_cmd_pend | {cpu_wdata[`VLC_CMD_SLEEP], cpu_wdata[`VLC_CMD_IDLE],
					                                 cpu_wdata[`VLC_CMD_ACTIVE]};
					next_rearb_pend = rearb_pend | cpu_wdata[`VLC_CMD_REARB];
					if (cpu_wdata[`VLC_CMD_MANUAL_TICK]) begin
						next_manual_cnt = `VLC_MANUAL_TICK_SLOTS;
					end
				end
				default: begin
				end
			endcase
		end

		// Mode commands land on a timeslot boundary; a sleeping part has no ticks.
		if ((tk.ts_tick || mode == VLC_MODE_SLEEP) && cmd_pend != 3'h0) begin
			if (cmd_pend[2] && mode != VLC_MODE_SLEEP) begin
				next_mode = VLC_MODE_SLEEP;
			end else if (cmd_pend[1]) begin
				next_mode = VLC_MODE_IDLE;
			end else if (cmd_pend[0]) begin
				next_mode = VLC_MODE_ACTIVE;
			end
			next_cmd_pend = 3'h0;
		end

		if (tk.ts_tick && manual_cnt != 2'h0) begin
			next_manual_cnt = manual_cnt - 2'h1;
		end

		// Retry accounting; contention repeats the attempt with the count held.
		if (tx_error_evt) begin
			if (retry_count == max_retry) begin
				next_retry_exhausted = 1'b1;
				next_retry_count     = 4'h0;
			end else begin
				next_retry_req   = 1'b1;
				next_retry_count = retry_count + 4'h1;
			end
		end else if (contention_evt) begin
			next_retry_req = 1'b1;
		end else if (tx_success_evt) begin
			next_retry_count = 4'h0;
		end

		if (rearb_pend && (attempt_end || !tx_selected)) begin
			next_arbitration_restart = 1'b1;
			next_retry_count         = 4'h0;
			next_retry_exhausted     = 1'b0;
			next_retry_req           = 1'b0;
			next_rearb_pend          = 1'b0;
		end

		if (rd_hit) begin
			case (cpu_addr)
				`VLC_OFS_LINE_CONFIG:     next_cpu_rdata = line_config;
				`VLC_OFS_TRANSMIT_CONFIG: next_cpu_rdata = {max_retry, REVISION, module_kind};
				`VLC_OFS_DIAG_CONFIG:     next_cpu_rdata = diagnosis_config;
				`VLC_OFS_LINE_STATE: begin
					next_cpu_rdata = {1'b0, mode == VLC_MODE_SLEEP, mode == VLC_MODE_IDLE, input_mismatch_flag,
					                  diag_state, tx_pending_flag, bus_activity_flag};
				end
				default:                  next_cpu_rdata = `VLC_READ_ABSENT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Line path and diagnosis status
	// ----------------------------------------------------------------
	assign attempt_end = tx_error_evt || contention_evt || tx_success_evt;
	assign rx_in       = {line_rx_in2, line_rx_in1, line_rx_in0} ^ {3{line_config[`VLC_LC_RX_FLIP]}};
	assign mism_now    = !line_config[`VLC_LC_PULSE] && (rx_in != 3'h0) && (rx_in != 3'h7);
	assign ri_now      = eof_detect && (diagnosis_config[`VLC_DC_SEL_HI:`VLC_DC_SEL_LO] != `VLC_SEL_AUTO);

	always_comb begin
		eff_sel = diagnosis_config[`VLC_DC_SEL_HI:`VLC_DC_SEL_LO];
		if (eff_sel == `VLC_SEL_AUTO) begin
			eff_sel = diag_result;
		end
		case (eff_sel)
			2'h1:    next_rx_data = rx_in[2];
			2'h2:    next_rx_data = rx_in[1];
			default: next_rx_data = rx_in[0];
		endcase
		if (line_config[`VLC_LC_PULSE]) begin
			next_rx_data = rx_in[0];
		end
		// Idle parks the line at recessive with the driver off.
		next_line_tx_out = ((mode == VLC_MODE_ACTIVE) ? tx_bit : 1'b1) ^ line_config[`VLC_LC_TX_FLIP];
		next_line_tx_oe  = (mode == VLC_MODE_ACTIVE);
		next_input_mismatch_flag  = mism_now || (input_mismatch_flag && !ri_now);
		next_tx_pending_flag      = tx_selected;
		next_bus_activity_flag    = bus_busy;
		next_diag_state           = line_config[`VLC_LC_PULSE] ? 2'h0 : diag_result;
		next_tx_active_window     = diagnosis_config[`VLC_DC_TX_DIAG] && tx_in_progress;
		next_sync_diag_tick       = tk.sdc_tick || (manual_cnt != 2'h0);
		next_return_to_idle_pulse = ri_now;
		if (mode == VLC_MODE_SLEEP) begin
			next_input_mismatch_flag = 1'b0;
			next_tx_active_window    = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_config          <= `VLC_RST_LINE_CONFIG;
			max_retry            <= `VLC_RST_MAX_RETRY;
			module_kind          <= `VLC_RST_MODULE_KIND;
			diagnosis_config     <= `VLC_RST_DIAG_CONFIG;
			mode                 <= VLC_MODE_IDLE;
			cmd_pend             <= 3'h0;
			rearb_pend           <= 1'b0;
			manual_cnt           <= 2'h0;
			soft_rst             <= 1'b0;
			input_mismatch_flag  <= 1'b0;
			tx_pending_flag      <= 1'b0;
			bus_activity_flag    <= 1'b0;
			diag_state           <= 2'h0;
			retry_count          <= 4'h0;
			retry_req            <= 1'b0;
			retry_exhausted      <= 1'b0;
			arbitration_restart  <= 1'b0;
			cpu_rdata            <= 8'h00;
			line_tx_out          <= 1'b1;
			line_tx_oe           <= 1'b0;
			rx_data              <= 1'b0;
			tx_active_window     <= 1'b0;
			sync_diag_tick       <= 1'b0;
			return_to_idle_pulse <= 1'b0;
			frame_enable         <= 1'b0;
			pulse_coding_sel     <= 1'b0;
			diag_enable          <= 1'b1;
			diag_select          <= 2'h0;
			osc_run              <= 1'b1;
			timeslot_clock       <= 1'b0;
		end else if (soft_rst) begin
			// Same values as the pin reset; the command bit drops by itself here.
			line_config          <= `VLC_RST_LINE_CONFIG;
			max_retry            <= `VLC_RST_MAX_RETRY;
			module_kind          <= `VLC_RST_MODULE_KIND;
			diagnosis_config     <= `VLC_RST_DIAG_CONFIG;
			mode                 <= VLC_MODE_IDLE;
			cmd_pend             <= 3'h0;
			rearb_pend           <= 1'b0;
			manual_cnt           <= 2'h0;
			soft_rst             <= 1'b0;
			input_mismatch_flag  <= 1'b0;
			tx_pending_flag      <= 1'b0;
			bus_activity_flag    <= 1'b0;
			diag_state           <= 2'h0;
			retry_count          <= 4'h0;
			retry_req            <= 1'b0;
			retry_exhausted      <= 1'b0;
			arbitration_restart  <= 1'b0;
			cpu_rdata            <= 8'h00;
			line_tx_out          <= 1'b1;
			line_tx_oe           <= 1'b0;
			rx_data              <= 1'b0;
			tx_active_window     <= 1'b0;
			sync_diag_tick       <= 1'b0;
			return_to_idle_pulse <= 1'b0;
			frame_enable         <= 1'b0;
			pulse_coding_sel     <= 1'b0;
			diag_enable          <= 1'b1;
			diag_select          <= 2'h0;
			osc_run              <= 1'b1;
			timeslot_clock       <= 1'b0;
		end else begin
			line_config          <= next_line_config;
			max_retry            <= next_max_retry;
			module_kind          <= next_module_kind;
			diagnosis_config     <= next_diagnosis_config;
			mode                 <= next_mode;
			cmd_pend             <= next_cmd_pend;
			rearb_pend           <= next_rearb_pend;
			manual_cnt           <= next_manual_cnt;
			soft_rst             <= next_soft_rst;
			input_mismatch_flag  <= next_input_mismatch_flag;
			tx_pending_flag      <= next_tx_pending_flag;
			bus_activity_flag    <= next_bus_activity_flag;
			diag_state           <= next_diag_state;
			retry_count          <= next_retry_count;
			retry_req            <= next_retry_req;
			retry_exhausted      <= next_retry_exhausted;
			arbitration_restart  <= next_arbitration_restart;
			cpu_rdata            <= next_cpu_rdata;
			line_tx_out          <= next_line_tx_out;
			line_tx_oe           <= next_line_tx_oe;
			rx_data              <= next_rx_data;
			tx_active_window     <= next_tx_active_window;
			sync_diag_tick       <= next_sync_diag_tick;
			return_to_idle_pulse <= next_return_to_idle_pulse;
			frame_enable         <= (mode == VLC_MODE_ACTIVE);
			pulse_coding_sel     <= next_line_config[`VLC_LC_PULSE];
			diag_enable          <= !next_line_config[`VLC_LC_PULSE];
			diag_select          <= next_diagnosis_config[`VLC_DC_SEL_HI:`VLC_DC_SEL_LO];
			osc_run              <= (mode != VLC_MODE_SLEEP);
			timeslot_clock       <= tk.ts_tick;
		end
	end

endmodule // vlc_line_regs

// File: bench/vlc_line_model.sv
`timescale 1ns/1ps
module vlc_line_model (
	// Transmit side
	input  wire logic line_tx_out,
	input  wire logic line_tx_oe,
	input  wire logic fault,
	// Receive side
	output logic      line_rx_in0,
	output logic      line_rx_in1,
	output logic      line_rx_in2
);
	logic lvl;
	// A released pair is pulled to the recessive level.
	assign lvl = line_tx_oe ? line_tx_out : 1'b1;
	assign line_rx_in0 = lvl;
	assign line_rx_in1 = lvl ^ fault;
	assign line_rx_in2 = lvl;
endmodule // vlc_line_model

// File: bench/vlc_line_regs_monitor.sv
`timescale 1ns/1ps
module vlc_line_regs_monitor (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       tx_in_progress,
	input wire logic       tx_error_evt,
	input wire logic       contention_evt,
	input wire logic       eof_detect,
	input wire logic       pulse_coding_sel,
	input wire logic       diag_enable,
	input wire logic       line_tx_oe,
	input wire logic       frame_enable,
	input wire logic       tx_active_window,
	input wire logic       retry_req,
	input wire logic       retry_exhausted,
	input wire logic [3:0] retry_count,
	input wire logic       arbitration_restart,
	input wire logic       return_to_idle_pulse,
	input wire logic [1:0] diag_select,
	input wire logic       timeslot_clock
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence err_taken; tx_error_evt; endsequence
	sequence retry_more; retry_req && !retry_exhausted; endsequence
	sequence give_up; retry_exhausted && retry_count == 4'h0; endsequence
	oe_active_a: assert property (line_tx_oe == frame_enable)
		else $error("driver enable differs from frame enable");
	pulse_diag_a: assert property (pulse_coding_sel |-> !diag_enable)
		else $error("diagnosis on in pulse coding");
	window_gate_a: assert property (tx_active_window |-> $past(tx_in_progress))
		else $error("transmit window without transmission");
	retry_cause_a: assert property (retry_req || retry_exhausted |-> $past(tx_error_evt) || (retry_req && $past(contention_evt)))
		else $error("retry outcome without error");
	err_outcome_a: assert property (err_taken |=> retry_more or give_up)
		else $error("error gave no retry outcome");
	contention_free_a: assert property (contention_evt && !tx_error_evt |=> arbitration_restart || (retry_req && !retry_exhausted && $stable(retry_count)))
		else $error("contention counted as error");
	arb_pulse_a: assert property (arbitration_restart |=> !arbitration_restart)
		else $error("restart pulse too long");
	idle_return_a: assert property (return_to_idle_pulse |-> $past(eof_detect) && $past(diag_select) != 2'h3)
		else $error("return to idle pulse without cause");
	ts_pulse_a: assert property (timeslot_clock |=> (!timeslot_clock) [*8])
		else $error("timeslot ticks too close");
endmodule // vlc_line_regs_monitor
bind vlc_line_regs vlc_line_regs_monitor mon (.*);

// File: bench/van_line_control_registers_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s expected %h seen %h", n, e, g); end end
`define WAIT(c, m) for (int w = 0; w < (m) && !(c); w++) @(negedge ref_clk);
module van_line_control_registers_bench;
	logic       ref_clk = 0, rst_n = 0, cpu_sel = 0, cpu_wr = 0, cpu_rd = 0, fault = 0, rd_d = 0;
	logic [7:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, d, e, q[$];
	logic       tx_bit = 1, tx_in_progress = 0, tx_selected = 0, bus_busy = 0, eof_detect = 0;
	logic       tx_error_evt = 0, contention_evt = 0, tx_success_evt = 0;
	logic [1:0] diag_result = 0, diag_select;
	logic [3:0] retry_count;
	logic       line_rx_in0, line_rx_in1, line_rx_in2, line_tx_out, line_tx_oe, rx_data, frame_enable;
	logic       pulse_coding_sel, diag_enable, module_kind, retry_req, retry_exhausted, arbitration_restart;
	logic       tx_active_window, sync_diag_tick, return_to_idle_pulse, osc_run, timeslot_clock;
	int         mismatches = 0, checks = 0, cyc = 0, seed = 69, p;
	vlc_line_regs uut (.*);
	vlc_line_model far (.line_tx_out, .line_tx_oe, .fault, .line_rx_in0, .line_rx_in1, .line_rx_in2);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic summarize();
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reads queue their expected value; the watcher below compares it.
	task automatic bus(input logic [7:0] a, input logic [7:0] v, input logic w);
		if (!w) q.push_back(v);
		@(posedge ref_clk);
		cpu_sel <= 1'b1;
		cpu_wr <= w;
		cpu_rd <= !w;
		cpu_addr <= a;
		cpu_wdata <= v;
		@(posedge ref_clk);
		cpu_sel <= 1'b0;
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
	endtask
	task automatic ev(input int k);
		@(posedge ref_clk);
		tx_error_evt <= (k == 0);
		contention_evt <= (k == 1);
		eof_detect <= (k == 2);
		@(posedge ref_clk);
		{tx_error_evt, contention_evt, eof_detect} <= 3'b000;
		@(negedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		rd_d <= cpu_sel & cpu_rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	always @(negedge ref_clk) if (rd_d) begin
		e = q.pop_front();
		`CHK("register read", e, cpu_rdata)
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		bus(8'h00, 8'h00, 0);
		bus(8'h01, 8'h0A, 0);
		bus(8'h02, 8'h00, 0);
		bus(8'h03, 8'h00, 0);
		bus(8'h04, 8'hFF, 1);
		bus(8'h04, 8'h20, 0);
		bus(8'h05, 8'h00, 0);
		bus(8'h01, 8'h1B, 1);
		bus(8'h01, 8'h1B, 0);
		@(negedge ref_clk);
		`CHK("module kind", 1'b1, module_kind)
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			bus(8'h02, d, 1);
			tx_in_progress <= 1'b1;
			bus(8'h02, d, 0);
			@(negedge ref_clk);
			`CHK("diagnosis select", d[3:2], diag_select)
			`CHK("transmit window", d[1], tx_active_window)
			@(posedge ref_clk);
			tx_in_progress <= 1'b0;
		end
		bus(8'h02, 8'h00, 1);
		for (int n = 1; n < 4; n++) begin
			bus(8'h00, 8'(n << 4), 1);
			`WAIT(timeslot_clock, 200)
			@(negedge ref_clk);
			`WAIT(timeslot_clock, 200)
			@(negedge ref_clk);
			for (p = 1; p < 200 && !timeslot_clock; p++) @(negedge ref_clk);
			`CHK("timeslot period", 16 * n, p)
		end
		bus(8'h00, 8'h12, 1);
		bus(8'h03, 8'h10, 1);
		`WAIT(line_tx_oe, 6 * 16 + 3)
		`CHK("driver enable", 1'b1, line_tx_oe)
		`CHK("frame enable", 1'b1, frame_enable)
		@(posedge ref_clk);
		tx_bit <= 1'b0;
		repeat (2) @(negedge ref_clk);
		`CHK("transmit level", 1'b1, line_tx_out)
		bus(8'h04, 8'h00, 0);
		fault <= 1'b1;
		repeat (20) @(posedge ref_clk);
		fault <= 1'b0;
		repeat (20) @(posedge ref_clk);
		bus(8'h04, 8'h10, 0);
		ev(2);
		`CHK("return to idle", 1'b1, return_to_idle_pulse)
		bus(8'h04, 8'h00, 0);
		bus(8'h02, 8'h0C, 1);
		ev(2);
		`CHK("return to idle", 1'b0, return_to_idle_pulse)
		bus(8'h02, 8'h00, 1);
		for (int m = 0; m < 3; m++) begin
			bus(8'h01, {m[3:0], 4'hA}, 1);
			for (int k = 0; k < m; k++) begin
				ev(0);
				`CHK("retry request", 1'b1, retry_req)
				ev(1);
				`CHK("retry count", k[3:0] + 4'h1, retry_count)
			end
			ev(0);
			`CHK("retry exhausted", 1'b1, retry_exhausted)
		end
		ev(0);
		bus(8'h03, 8'h08, 1);
		`WAIT(arbitration_restart, 6 * 16 + 3)
		`CHK("restart", 1'b1, arbitration_restart)
		@(negedge ref_clk);
		`CHK("retry count", 4'h0, retry_count)
		bus(8'h03, 8'h20, 1);
		`WAIT(!line_tx_oe, 6 * 16 + 3)
		`CHK("idle level", 1'b0, line_tx_out)
		bus(8'h03, 8'h40, 1);
		`WAIT(!osc_run, 6 * 16 + 3)
		`CHK("oscillator", 1'b0, osc_run)
		bus(8'h04, 8'h40, 0);
		bus(8'h03, 8'h20, 1);
		`WAIT(osc_run, 8)
		bus(8'h04, 8'h20, 0);
		bus(8'h03, 8'h80, 1);
		repeat (4) @(posedge ref_clk);
		bus(8'h00, 8'h00, 0);
		bus(8'h01, 8'h0A, 0);
		bus(8'h00, 8'h08, 1);
		bus(8'h00, 8'h08, 0);
		`CHK("pulse coding", 1'b1, pulse_coding_sel)
		bus(8'h02, 8'h08, 1);
		fault <= 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHK("receive data", 1'b1, rx_data)
		bus(8'h00, 8'h00, 1);
		tx_selected <= 1'b1;
		bus_busy <= 1'b1;
		diag_result <= 2'h3;
		repeat (2) @(negedge ref_clk);
		`CHK("receive data", 1'b0, rx_data)
		bus(8'h04, 8'h3F, 0);
		bus(8'h03, 8'h01, 1);
		repeat (2) @(negedge ref_clk);
		`CHK("diagnosis tick", 1'b1, sync_diag_tick)
		repeat (40) @(negedge ref_clk);
		`CHK("diagnosis tick", 1'b0, sync_diag_tick)
		repeat (3) @(posedge ref_clk);
		summarize();
	end
endmodule // van_line_control_registers_bench
